// file: design/spm_params.svh
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SPM_OFS_FSEL_LO 8'h00
`define SPM_OFS_FSEL_HI 8'h04
`define SPM_OFS_GPIO_DIR 8'h08
`define SPM_OFS_GPIO_OUT 8'h0c
`define SPM_OFS_GPIO_IN 8'h10
`define SPM_OFS_FUNC_CTRL 8'h14
`define SPM_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPM_RST_FSEL 64'h0
`define SPM_RST_WORD 32'h0
`define SPM_RST_CTRL 6'h0
`define SPM_RST_ID 3'h0

// ----------------------------------------------------------------
// function control bit positions
// ----------------------------------------------------------------
`define SPM_CTL_T0_OUT 0
`define SPM_CTL_T1_OUT 1
`define SPM_CTL_TSYN_OUT 2
`define SPM_CTL_RSYN_OUT 3
`define SPM_CTL_RSYN_LANE_B 4
`define SPM_CTL_RCLK_LANE_C 5
`define SPM_CTL_WIDTH 6

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define SPM_ST_ID_LSB 0
`define SPM_ST_ID_VALID 3
`define SPM_ST_REQ_LSB 4

// ----------------------------------------------------------------
// physical line assignment of the shared group
// ----------------------------------------------------------------
`define SPM_LN_STRAP0 0
`define SPM_LN_COUNTER_LINE_0 1
`define SPM_LN_COUNTER_LINE_1 2
`define SPM_LN_TSYN 3
`define SPM_LN_TCLK 4
`define SPM_LN_TDAT 5
`define SPM_LN_RSYN 6
`define SPM_LN_RCLK 7
`define SPM_LN_RDAT 8
`define SPM_LN_REQ_FIRST 3
`define SPM_NUM_REQ 6
`define SPM_NUM_MUXED 9
`define SPM_ID_WIDTH 3

`endif

// file: design/spm_pkg.sv
package spm_pkg;

  // per-line function select code
  typedef enum logic [1:0] {
    SPM_FN_GPIO = 2'h0,
    SPM_FN_PERIPH = 2'h1,
    SPM_FN_REQ = 2'h2,
    SPM_FN_NONE = 2'h3
  } spm_func_t;

  typedef logic [2:0] spm_id_t;

endpackage

// file: design/spm_strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"

module spm_strap_capture (
  input wire logic mclk,
  input wire logic srst,
  input wire logic power_on_reset_in,
  input wire spm_pkg::spm_id_t strap_in,
  output spm_pkg::spm_id_t id_ff,
  output logic id_valid_ff
);
  import spm_pkg::*;

  logic por_prev_ff;

  // ----------------------------------------------------------------
  // release detect: low in one cycle, high in the next
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      por_prev_ff <= 1'b0;
    end else begin
      por_prev_ff <= power_on_reset_in;
    end
  end

  // straps taken once per release; later strap moves are ignored
  // capture on release
  always_ff @(posedge mclk) begin
    if (srst) begin
      id_ff <= `SPM_RST_ID;
      id_valid_ff <= 1'b0;
    end else if (!power_on_reset_in) begin
      id_valid_ff <= 1'b0;
    end else if (!por_prev_ff) begin
      id_ff <= strap_in;
      id_valid_ff <= 1'b1;
    end
  end

endmodule // spm_strap_capture
`default_nettype wire

// file: design/spm_pin_mux.sv
// Function
// - selected function alone owns each line
// - 32 lines: gpio or dedicated in/out
// - identity straps captured at reset release
// - counter lines direction set by configuration
// - request lines forwarded to interrupt controller
// - tx data output carries lane D
// - rx frame sync input may be lane B
// - rx clock output may be lane C
// - rx data input also feeds lane A
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"

module spm_pin_mux #(
  parameter int NUM_LINES = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic power_on_reset_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_LINES-1:0] pad_in,
  output logic [NUM_LINES-1:0] pad_out,
  output logic [NUM_LINES-1:0] pad_oe,
  input wire logic counter_line_0_out,
  input wire logic counter_line_1_out,
  output logic counter_line_0_in,
  output logic counter_line_1_in,
  input wire logic serial3_tx_frame_sync_out,
  output logic serial3_tx_frame_sync,
  output logic serial3_tx_clock,
  input wire logic serial3_lane_d_out,
  input wire logic serial3_rx_frame_sync_out,
  output logic serial3_rx_frame_sync,
  output logic serial3_lane_b,
  output logic serial3_rx_clock,
  input wire logic serial3_lane_c_out,
  output logic serial3_rx_data,
  output logic serial3_lane_a,
  output logic [`SPM_NUM_REQ:1] ext_request_line,
  output spm_pkg::spm_id_t host_port_id,
  output logic host_port_id_valid
);
  import spm_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the select registers hold exactly 32 two-bit fields
  if (NUM_LINES != 32) begin : g_bad_lines
    $error("spm_pin_mux: NUM_LINES must be 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [63:0] fsel_ff;
  logic [31:0] gpio_dir_ff;
  logic [31:0] gpio_out_ff;
  logic [`SPM_CTL_WIDTH-1:0] ctrl_ff;
  logic [31:0] rdata_ff;
  logic [NUM_LINES-1:0] pad_out_ff;
  logic [NUM_LINES-1:0] pad_oe_ff;
  logic [NUM_LINES-1:0] nxt_pad_out;
  logic [NUM_LINES-1:0] nxt_pad_oe;
  logic [8:0] to_core_ff;
  logic [8:0] nxt_to_core;
  logic [`SPM_NUM_REQ:1] req_ff;
  logic [`SPM_NUM_REQ:1] nxt_req;
  logic [31:0] nxt_rdata;
  logic cfg_rst;
  spm_id_t id_ff;
  logic id_valid_ff;

  // function select of one line
  function automatic spm_func_t line_fn(input logic [63:0] sel, input int idx);
    line_fn = spm_func_t'(sel[2*idx +: 2]);
  endfunction

  // configuration returns to defaults on either reset
  assign cfg_rst = srst | ~power_on_reset_in;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // software steers the mux through these fields
  always_ff @(posedge mclk) begin
    if (cfg_rst) begin
      fsel_ff <= `SPM_RST_FSEL;
      gpio_dir_ff <= `SPM_RST_WORD;
      gpio_out_ff <= `SPM_RST_WORD;
      ctrl_ff <= `SPM_RST_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `SPM_OFS_FSEL_LO: fsel_ff[31:0] <= reg_wdata;
        `SPM_OFS_FSEL_HI: fsel_ff[63:32] <= reg_wdata;
        `SPM_OFS_GPIO_DIR: gpio_dir_ff <= reg_wdata;
        `SPM_OFS_GPIO_OUT: gpio_out_ff <= reg_wdata;
        `SPM_OFS_FUNC_CTRL: ctrl_ff <= reg_wdata[`SPM_CTL_WIDTH-1:0];
        default: ; // read-only or unmapped: write ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0;
    case (reg_addr)
      `SPM_OFS_FSEL_LO: nxt_rdata = fsel_ff[31:0];
      `SPM_OFS_FSEL_HI: nxt_rdata = fsel_ff[63:32];
      `SPM_OFS_GPIO_DIR: nxt_rdata = gpio_dir_ff;
      `SPM_OFS_GPIO_OUT: nxt_rdata = gpio_out_ff;
      `SPM_OFS_GPIO_IN: nxt_rdata = pad_in;
      `SPM_OFS_FUNC_CTRL: nxt_rdata[`SPM_CTL_WIDTH-1:0] = ctrl_ff;
      `SPM_OFS_STATUS: begin
        nxt_rdata[`SPM_ST_ID_LSB +: `SPM_ID_WIDTH] = id_ff;
        nxt_rdata[`SPM_ST_ID_VALID] = id_valid_ff;
        nxt_rdata[`SPM_ST_REQ_LSB +: `SPM_NUM_REQ] = req_ff;
      end
      default: nxt_rdata = 32'h0;
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_ff <= `SPM_RST_WORD;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : `SPM_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  // one owner per line
  always_comb begin
    nxt_pad_out = '0;
    nxt_pad_oe = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (line_fn(fsel_ff, i) == SPM_FN_GPIO) begin
        nxt_pad_out[i] = gpio_out_ff[i];
        nxt_pad_oe[i] = gpio_dir_ff[i];
      end
    end
    if (line_fn(fsel_ff, `SPM_LN_COUNTER_LINE_0) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_COUNTER_LINE_0] = counter_line_0_out;
      nxt_pad_oe[`SPM_LN_COUNTER_LINE_0] = ctrl_ff[`SPM_CTL_T0_OUT];
    end
    if (line_fn(fsel_ff, `SPM_LN_COUNTER_LINE_1) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_COUNTER_LINE_1] = counter_line_1_out;
      nxt_pad_oe[`SPM_LN_COUNTER_LINE_1] = ctrl_ff[`SPM_CTL_T1_OUT];
    end
    // tx frame sync may go either way
    if (line_fn(fsel_ff, `SPM_LN_TSYN) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_TSYN] = serial3_tx_frame_sync_out;
      nxt_pad_oe[`SPM_LN_TSYN] = ctrl_ff[`SPM_CTL_TSYN_OUT];
    end
    if (line_fn(fsel_ff, `SPM_LN_TCLK) == SPM_FN_PERIPH) begin
      nxt_pad_oe[`SPM_LN_TCLK] = 1'b0;
    end
    if (line_fn(fsel_ff, `SPM_LN_TDAT) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_TDAT] = serial3_lane_d_out;
      nxt_pad_oe[`SPM_LN_TDAT] = 1'b1;
    end
    // lane B use forces rx sync to input
    if (line_fn(fsel_ff, `SPM_LN_RSYN) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_RSYN] = serial3_rx_frame_sync_out;
      nxt_pad_oe[`SPM_LN_RSYN] = ctrl_ff[`SPM_CTL_RSYN_OUT] & ~ctrl_ff[`SPM_CTL_RSYN_LANE_B];
    end
    // rx clock line outputs lane C
    if (line_fn(fsel_ff, `SPM_LN_RCLK) == SPM_FN_PERIPH) begin
      nxt_pad_out[`SPM_LN_RCLK] = serial3_lane_c_out;
      nxt_pad_oe[`SPM_LN_RCLK] = ctrl_ff[`SPM_CTL_RCLK_LANE_C];
    end
    // rx data and request lines are inputs only
    if (line_fn(fsel_ff, `SPM_LN_RDAT) != SPM_FN_GPIO) begin
      nxt_pad_oe[`SPM_LN_RDAT] = 1'b0;
    end
    // lines stay released while power-on reset holds so straps read clean
    if (!power_on_reset_in) begin
      nxt_pad_oe = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff <= nxt_pad_oe;
    end
  end

  // ----------------------------------------------------------------
  // inputs toward the peripherals
  // ----------------------------------------------------------------
  // unselected destinations see zero so no stray edges leak in
  always_comb begin
    nxt_to_core = '0;
    if (line_fn(fsel_ff, `SPM_LN_COUNTER_LINE_0) == SPM_FN_PERIPH && !ctrl_ff[`SPM_CTL_T0_OUT]) begin
      nxt_to_core[0] = pad_in[`SPM_LN_COUNTER_LINE_0];
    end
    if (line_fn(fsel_ff, `SPM_LN_COUNTER_LINE_1) == SPM_FN_PERIPH && !ctrl_ff[`SPM_CTL_T1_OUT]) begin
      nxt_to_core[1] = pad_in[`SPM_LN_COUNTER_LINE_1];
    end
    if (line_fn(fsel_ff, `SPM_LN_TSYN) == SPM_FN_PERIPH && !ctrl_ff[`SPM_CTL_TSYN_OUT]) begin
      nxt_to_core[2] = pad_in[`SPM_LN_TSYN];
    end
    if (line_fn(fsel_ff, `SPM_LN_TCLK) == SPM_FN_PERIPH) begin
      nxt_to_core[3] = pad_in[`SPM_LN_TCLK];
    end
    // rx sync input as lane B
    if (line_fn(fsel_ff, `SPM_LN_RSYN) == SPM_FN_PERIPH && !nxt_pad_oe[`SPM_LN_RSYN]) begin
      if (ctrl_ff[`SPM_CTL_RSYN_LANE_B]) begin
        nxt_to_core[5] = pad_in[`SPM_LN_RSYN];
      end else begin
        nxt_to_core[4] = pad_in[`SPM_LN_RSYN];
      end
    end
    if (line_fn(fsel_ff, `SPM_LN_RCLK) == SPM_FN_PERIPH && !ctrl_ff[`SPM_CTL_RCLK_LANE_C]) begin
      nxt_to_core[6] = pad_in[`SPM_LN_RCLK];
    end
    // rx data line feeds lane A
    if (line_fn(fsel_ff, `SPM_LN_RDAT) == SPM_FN_PERIPH) begin
      nxt_to_core[7] = pad_in[`SPM_LN_RDAT];
      nxt_to_core[8] = pad_in[`SPM_LN_RDAT];
    end
  end

  // request lines, active low on the pin
  always_comb begin
    nxt_req = '0;
    for (int k = 1; k <= `SPM_NUM_REQ; k++) begin
      if (line_fn(fsel_ff, `SPM_LN_REQ_FIRST + k - 1) == SPM_FN_REQ) begin
        nxt_req[k] = ~pad_in[`SPM_LN_REQ_FIRST + k - 1];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      to_core_ff <= '0;
      req_ff <= '0;
    end else begin
      to_core_ff <= nxt_to_core;
      req_ff <= nxt_req;
    end
  end

  // ----------------------------------------------------------------
  // identity straps
  // ----------------------------------------------------------------
  // relies on straps steady at release
  spm_strap_capture u_strap (
    .mclk(mclk),
    .srst(srst),
    .power_on_reset_in(power_on_reset_in),
    .strap_in(pad_in[`SPM_LN_STRAP0 +: `SPM_ID_WIDTH]),
    .id_ff(id_ff),
    .id_valid_ff(id_valid_ff)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign counter_line_0_in = to_core_ff[0];
  assign counter_line_1_in = to_core_ff[1];
  assign serial3_tx_frame_sync = to_core_ff[2];
  assign serial3_tx_clock = to_core_ff[3];
  assign serial3_rx_frame_sync = to_core_ff[4];
  assign serial3_lane_b = to_core_ff[5];
  assign serial3_rx_clock = to_core_ff[6];
  assign serial3_rx_data = to_core_ff[7];
  assign serial3_lane_a = to_core_ff[8];
  assign ext_request_line = req_ff;
  assign host_port_id = id_ff;
  assign host_port_id_valid = id_valid_ff;

endmodule // spm_pin_mux
`default_nettype wire

// file: sim/spm_pin_mux_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"
// ------------------------------------------------
// port checks of the shared line mux
// ------------------------------------------------
module spm_mux_chk #(
  parameter int NUM_LINES = 32
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic power_on_reset_in,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_LINES-1:0] pad_in,
  input wire logic [NUM_LINES-1:0] pad_oe,
  input wire logic counter_line_0_in,
  input wire logic serial3_tx_clock,
  input wire logic serial3_lane_b,
  input wire logic serial3_rx_clock,
  input wire logic serial3_rx_data,
  input wire logic serial3_lane_a,
  input wire logic [`SPM_NUM_REQ:1] ext_request_line,
  input wire spm_pkg::spm_id_t host_port_id,
  input wire logic host_port_id_valid
);
  import spm_pkg::*;
  // one domain, so clock and reset are set once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped; reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_por_off; !power_on_reset_in |=> pad_oe == '0; endproperty
  a_por_off: assert property (p_por_off) else $error("pad driven in power-on reset");
  property p_id_cap; $rose(power_on_reset_in) |=> host_port_id == $past(pad_in[2:0]) && host_port_id_valid;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("identity not captured at release");
  // late captures would change the host identity under software
  property p_id_hold; power_on_reset_in && $past(power_on_reset_in) && !$past(srst) |=> $stable(host_port_id);
  endproperty
  a_id_hold: assert property (p_id_hold) else $error("identity moved after release");
  property p_req; ext_request_line != 6'h0 |-> (ext_request_line & $past(pad_in[8:3])) == 6'h0; endproperty
  a_req: assert property (p_req) else $error("request without low pin");
  property p_tclk; serial3_tx_clock |-> $past(pad_in[4]); endproperty
  a_tclk: assert property (p_tclk) else $error("tx clock not from its line");
  property p_lane_b; serial3_lane_b |-> $past(pad_in[6]); endproperty
  a_lane_b: assert property (p_lane_b) else $error("lane b not from its line");
  property p_rclk; serial3_rx_clock |-> $past(pad_in[7]); endproperty
  a_rclk: assert property (p_rclk) else $error("rx clock not from its line");
  property p_lane_a; serial3_lane_a |-> $past(pad_in[8]) && serial3_rx_data; endproperty
  a_lane_a: assert property (p_lane_a) else $error("lane a not from rx data line");
  property p_tmr; counter_line_0_in |-> $past(pad_in[1]); endproperty
  a_tmr: assert property (p_tmr) else $error("counter input not from its line");
  c_id: cover property ($rose(host_port_id_valid));
  c_req: cover property (ext_request_line != 6'h0);
  c_lane_c: cover property (pad_oe[7]);
endmodule // spm_mux_chk
`default_nettype wire

// file: sim/spm_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// board: peripherals, strap resistors, pull-ups
// ------------------------------------------------
module spm_board_model (
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] drv_en,
  input wire logic [31:0] drv_val,
  input wire spm_pkg::spm_id_t strap,
  output logic [31:0] pad_in
);
  import spm_pkg::*;
  // straps held
  // strap resistors never move, so the capture is always valid; free lines pull up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv_val) | (~pad_oe & ~drv_en & {29'h1fffffff, strap});
endmodule // spm_board_model
`default_nettype wire

// file: sim/tb_shared_pin_group_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"
module tb_shared_pin_group_mux;
  import spm_pkg::*;
  logic mclk, srst, power_on_reset_in, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pad_in, pad_out, pad_oe, drv_en, drv_val;
  logic [5:0] side_drv;
  logic [`SPM_NUM_REQ:1] ext_request_line;
  logic counter_line_0_in, serial3_tx_clock, serial3_lane_b, serial3_rx_clock, serial3_rx_data, serial3_lane_a;
  logic counter_line_1_in, serial3_tx_frame_sync, serial3_rx_frame_sync;
  logic host_port_id_valid;
  spm_id_t host_port_id, strap;
  int error_cnt = 0;
  int samples_checked = 0;
  spm_pin_mux dut_u (.mclk(mclk), .srst(srst), .power_on_reset_in(power_on_reset_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .counter_line_0_out(side_drv[0]), .counter_line_1_out(side_drv[1]),
    .counter_line_0_in(counter_line_0_in), .counter_line_1_in(counter_line_1_in),
    .serial3_tx_frame_sync_out(side_drv[2]), .serial3_tx_frame_sync(serial3_tx_frame_sync),
    .serial3_tx_clock(serial3_tx_clock), .serial3_lane_d_out(side_drv[3]),
    .serial3_rx_frame_sync_out(side_drv[4]), .serial3_rx_frame_sync(serial3_rx_frame_sync),
    .serial3_lane_b(serial3_lane_b), .serial3_rx_clock(serial3_rx_clock), .serial3_lane_c_out(side_drv[5]),
    .serial3_rx_data(serial3_rx_data),
    .serial3_lane_a(serial3_lane_a), .ext_request_line(ext_request_line), .host_port_id(host_port_id),
    .host_port_id_valid(host_port_id_valid));
  spm_board_model brd_u (.pad_out(pad_out), .pad_oe(pad_oe), .drv_en(drv_en), .drv_val(drv_val), .strap(strap),
    .pad_in(pad_in));
  // ------------------------------------------------
  // bus and pin helpers
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data live only in the cycle after the strobe
  task automatic rchk(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic pins(logic [31:0] en, logic [31:0] val, logic [5:0] side);
    @(posedge mclk);
    drv_en <= en;
    drv_val <= val;
    side_drv <= side;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_id;
    int n;
    repeat (4) @(posedge mclk);
    power_on_reset_in <= 1'b1;
    #1 chk("oe in por", 32'h0, pad_oe);
    for (n = 0; n < 8 && host_port_id_valid !== 1'b1; n++) @(posedge mclk);
    #1 chk("id", 32'hd, {28'h0, host_port_id_valid, host_port_id});
    wr(`SPM_OFS_STATUS, 32'hffffffff);
    rchk("status", `SPM_OFS_STATUS, 32'hd);
    rchk("unmapped", 8'h40, 32'h0);
    $display("test id done");
  endtask
  task automatic t_gpio;
    wr(`SPM_OFS_GPIO_DIR, 32'hffffffff);
    wr(`SPM_OFS_GPIO_OUT, 32'h5a5ac3c3);
    wr(`SPM_OFS_FSEL_HI, 32'hffffffff);
    pins(32'h0, 32'h0, 6'h0);
    chk("gpio oe", 32'h0000ffff, pad_oe);
    chk("gpio out", 32'h0000c3c3, pad_out & pad_oe);
    wr(`SPM_OFS_GPIO_DIR, 32'h0);
    wr(`SPM_OFS_FSEL_HI, 32'h0);
    pins(32'hffffffff, 32'h12345678, 6'h0);
    chk("gpio in oe", 32'h0, pad_oe);
    rchk("gpio in", `SPM_OFS_GPIO_IN, 32'h12345678);
    $display("test gpio done");
  endtask
  task automatic t_periph;
    wr(`SPM_OFS_FSEL_LO, 32'h00015554);
    wr(`SPM_OFS_FUNC_CTRL, 32'h21);
    pins(32'h0, 32'h0, 6'h29);
    chk("periph oe", 32'h0a2, pad_oe & 32'h1ff);
    // line 0 is still gpio and shows bit 0 of the gpio output word
    chk("periph out", 32'h0a3, pad_out & 32'h1ff);
    wr(`SPM_OFS_FUNC_CTRL, 32'h30);
    for (int v = 0; v < 2; v++) begin
      // tx clock edges from the partner
      pins(32'h152, v ? 32'h152 : 32'h0, 6'h20);
      // tx data line keeps driving lane d in every mode
      chk("in oe", 32'h0a0, pad_oe & 32'h1ff);
      chk("ins", v ? 32'h1f : 32'h0,
        {27'h0, counter_line_0_in, serial3_tx_clock, serial3_lane_b, serial3_lane_a, serial3_rx_data});
    end
    // timer 1, tx sync and rx sync turned to outputs
    wr(`SPM_OFS_FUNC_CTRL, 32'h0e);
    rchk("ctrl", `SPM_OFS_FUNC_CTRL, 32'h0e);
    pins(32'h1fe, 32'h180, 6'h16);
    chk("out dir oe", 32'h06c, pad_oe & 32'h1ff);
    chk("out dir out", 32'h04d, pad_out & 32'h1ff);
    chk("out dir ins", 32'h1,
      {28'h0, counter_line_1_in, serial3_tx_frame_sync, serial3_rx_frame_sync, serial3_rx_clock});
    // all but tx data back to inputs, lanes b and c off
    wr(`SPM_OFS_FUNC_CTRL, 32'h0);
    pins(32'h1fe, 32'h0cc, 6'h0);
    chk("in dir oe", 32'h020, pad_oe & 32'h1ff);
    chk("in dir ins", 32'h0f,
      {27'h0, serial3_lane_b, counter_line_1_in, serial3_tx_frame_sync, serial3_rx_frame_sync, serial3_rx_clock});
    $display("test periph done");
  endtask
  task automatic t_req;
    wr(`SPM_OFS_FSEL_LO, 32'h0002aa80);
    pins(32'h1f8, 32'h150, 6'h3f);
    chk("req oe", 32'h0, pad_oe & 32'h1f8);
    chk("req", 32'h15, {26'h0, ext_request_line});
    rchk("req status", `SPM_OFS_STATUS, 32'h15d);
    rchk("fsel", `SPM_OFS_FSEL_LO, 32'h0002aa80);
    pins(32'h1f8, 32'h1f8, 6'h3f);
    chk("req off", 32'h0, {26'h0, ext_request_line});
    $display("test req done");
  endtask
  initial begin
    srst <= 1'b1;
    power_on_reset_in <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h0;
    reg_wdata <= 32'h0;
    drv_en <= 32'h0;
    drv_val <= 32'h0;
    side_drv <= 6'h0;
    strap <= 3'h5;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_id();
    t_gpio();
    t_periph();
    t_req();
    close_out();
  end
  // hang guard
  initial begin
    #200us;
    error_cnt++;
    close_out();
  end
endmodule // tb_shared_pin_group_mux
bind spm_pin_mux spm_mux_chk #(.NUM_LINES(NUM_LINES)) chk_u (.mclk(mclk), .srst(srst),
  .power_on_reset_in(power_on_reset_in), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pad_in(pad_in), .pad_oe(pad_oe), .counter_line_0_in(counter_line_0_in), .serial3_tx_clock(serial3_tx_clock),
  .serial3_lane_b(serial3_lane_b), .serial3_rx_clock(serial3_rx_clock), .serial3_rx_data(serial3_rx_data),
  .serial3_lane_a(serial3_lane_a), .ext_request_line(ext_request_line), .host_port_id(host_port_id),
  .host_port_id_valid(host_port_id_valid));
`default_nettype wire
